/* File: shared/remote_pos_defines.svh */
`ifndef REMOTE_POS_DEFINES_SVH
`define REMOTE_POS_DEFINES_SVH

// remote word indices within the station's write-word block
`define RW_POS_LO_IDX 4'h4
`define RW_POS_HI_IDX 4'h5
`define RW_SPEED_IDX 4'h6

// reset value of every remote word
`define RW_RESET_VAL 16'h0000

// lowest digit of the command system parameter
`define CS_DIGIT_ABS 4'h0
`define CS_DIGIT_INCR 4'h1

// lowest digit of the position/speed source parameter
`define PS_DIGIT_REMOTE 4'h2

// point table that supplies accel/decel time constants
`define ACCDEC_TABLE_NO 8'h01
`define ACCDEC_RESET 8'h00

// accepted position ranges, 32-bit two's complement
`define POS_ABS_MAX 32'h0098967f
`define POS_ABS_MIN 32'hff676981
`define POS_INC_MAX 32'h000f423f
`define POS_INC_MIN 32'hfff0bdc1
`define POS_ZERO 32'h00000000

`endif

/* File: shared/remote_pos_pkg.sv */
package remote_pos_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } move_state_type;

endpackage : remote_pos_pkg

/* File: rtl/remote_word_regs.sv */
`timescale 1ns/1ps
`include "remote_pos_defines.svh"

module remote_word_regs #(
    parameter int WORD_W = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wr_en_i,
    input wire logic [3:0] idx_i,
    input wire logic [WORD_W-1:0] data_i,
    output logic [2*WORD_W-1:0] pos_o,
    output logic [WORD_W-1:0] speed_o
);

    function automatic logic [3:0] word_idx(input int slot);
        case (slot)
            0: word_idx = `RW_POS_LO_IDX;
            1: word_idx = `RW_POS_HI_IDX;
            default: word_idx = `RW_SPEED_IDX;
        endcase
    endfunction : word_idx

    logic [WORD_W-1:0] words_ff [3];
    logic [WORD_W-1:0] nxt_words [3];

    for (genvar g = 0; g < 3; g++) begin : g_word
        always_comb begin
            nxt_words[g] = words_ff[g];
            if (wr_en_i && (idx_i == word_idx(g))) begin
                nxt_words[g] = data_i;
            end
        end

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                words_ff[g] <= WORD_W'(`RW_RESET_VAL);
            end else begin
                words_ff[g] <= nxt_words[g];
            end
        end
    end

    // upper word on top, lower word below
    assign pos_o = {words_ff[1], words_ff[0]};
    assign speed_o = words_ff[2];

endmodule : remote_word_regs

/* File: rtl/pos_range_check.sv */
`timescale 1ns/1ps
`include "remote_pos_defines.svh"

module pos_range_check (
    input wire logic [31:0] pos_i,
    input wire logic incr_sys_i,
    input wire logic incr_sel_i,
    output logic in_range_o
);

    logic signed [31:0] pos_s;

    assign pos_s = $signed(pos_i);

    always_comb begin
        if (incr_sys_i) begin
            in_range_o = (pos_s >= $signed(`POS_ZERO)) && (pos_s <= $signed(`POS_INC_MAX));
        end else if (incr_sel_i) begin
            in_range_o = (pos_s >= $signed(`POS_INC_MIN)) && (pos_s <= $signed(`POS_INC_MAX));
        end else begin
            in_range_o = (pos_s >= $signed(`POS_ABS_MIN)) && (pos_s <= $signed(`POS_ABS_MAX));
        end
    end

endmodule : pos_range_check

/* File: rtl/remote_pos_cmd.sv */
// Overview of operation
// - remote position and speed words exist only while the driver occupies two stations.
// - with auto mode and remote source select both on, target and speed come from remote words.
// - command system digit 0 means absolute system, digit 1 means incremental system.
// - source parameter digit 2 enables the remote position and speed scheme.
// - accel and decel time constants are taken from point table one in remote mode.
// - the target is the high word on top of the low word, one 32-bit value.
// - absolute system with absolute data accepts -9999999 to 9999999.
// - absolute system with incremental data accepts -999999 to 999999.
// - incremental system accepts only 0 to 999999.
// - motor speed for the move comes from the speed command word.
// - in absolute system the abs/inc bit off means absolute data, on means increment.
// - the abs/inc bit is sampled when forward start rises and held for the whole move.
// - in incremental system data is always an increment and the abs/inc bit is ignored.
`timescale 1ns/1ps
`include "remote_pos_defines.svh"

module remote_pos_cmd #(
    parameter int WORD_W = 16
) (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic TWO_STATIONS_I,
    input wire logic AUTO_MANUAL_SELECT_I,
    input wire logic REMOTE_POSSPEED_SOURCE_SELECT_I,
    input wire logic ABS_INC_SELECT_I,
    input wire logic FORWARD_START_I,
    input wire logic [3:0] COMMAND_SYSTEM_PARAM_I,
    input wire logic [3:0] POSSPEED_SOURCE_PARAM_I,
    input wire logic RWW_WR_I,
    input wire logic [3:0] RWW_IDX_I,
    input wire logic [WORD_W-1:0] RWW_DATA_I,
    input wire logic MOVE_DONE_I,
    output logic REMOTE_MODE_O,
    output logic MOVE_START_O,
    output logic MOVE_BUSY_O,
    output logic MOVE_INCR_O,
    output logic [2*WORD_W-1:0] MOVE_TARGET_O,
    output logic [WORD_W-1:0] MOVE_SPEED_O,
    output logic [7:0] ACCDEC_TABLE_O,
    output logic RANGE_ERR_O
);

    if (WORD_W != 16) begin : g_bad_width
        $error("remote_pos_cmd: WORD_W must be 16");
    end

    // register words, write side

    logic [2*WORD_W-1:0] pos_word;
    logic [WORD_W-1:0] speed_word;
    logic regs_wr;

    // without the second station the remote words are not there at all
    assign regs_wr = RWW_WR_I && TWO_STATIONS_I;

    remote_word_regs #(
        .WORD_W(WORD_W)
    ) u_regs (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .wr_en_i(regs_wr),
        .idx_i(RWW_IDX_I),
        .data_i(RWW_DATA_I),
        .pos_o(pos_word),
        .speed_o(speed_word)
    );

    // mode decode

    logic remote_mode;
    logic incr_sys;
    logic cs_valid;
    logic incr_sel_now;
    logic range_ok;

    assign remote_mode = TWO_STATIONS_I && AUTO_MANUAL_SELECT_I
        && REMOTE_POSSPEED_SOURCE_SELECT_I
        && (POSSPEED_SOURCE_PARAM_I == `PS_DIGIT_REMOTE);
    assign incr_sys = (COMMAND_SYSTEM_PARAM_I == `CS_DIGIT_INCR);
    // any other digit is refused rather than guessed at
    assign cs_valid = incr_sys || (COMMAND_SYSTEM_PARAM_I == `CS_DIGIT_ABS);
    assign incr_sel_now = incr_sys || ABS_INC_SELECT_I;

    pos_range_check u_range (
        .pos_i(pos_word),
        .incr_sys_i(incr_sys),
        .incr_sel_i(ABS_INC_SELECT_I),
        .in_range_o(range_ok)
    );

    // start edge detect; start arrives from link logic on this clock

    logic fwd_q_ff;
    logic nxt_fwd_q;
    logic fwd_rise;

    always_comb begin
        nxt_fwd_q = FORWARD_START_I;
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fwd_q_ff <= 1'b0;
        end else begin
            fwd_q_ff <= nxt_fwd_q;
        end
    end

    assign fwd_rise = FORWARD_START_I && !fwd_q_ff;

    // move sequencing

    remote_pos_pkg::move_state_type state_ff;
    remote_pos_pkg::move_state_type nxt_state;
    logic start_req;
    logic accept;
    logic reject;

    // a start during a move is ignored, so later bit changes cannot leak in
    assign start_req = remote_mode && fwd_rise && (state_ff == remote_pos_pkg::ST_IDLE);
    assign accept = start_req && cs_valid && range_ok;
    assign reject = start_req && !(cs_valid && range_ok);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            remote_pos_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_state = remote_pos_pkg::ST_RUN;
                end
            end
            remote_pos_pkg::ST_RUN: begin
                if (MOVE_DONE_I) begin
                    nxt_state = remote_pos_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = remote_pos_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= remote_pos_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // move command latch

    logic start_ff;
    logic incr_ff;
    logic err_ff;
    logic [2*WORD_W-1:0] target_ff;
    logic [WORD_W-1:0] speed_ff;
    logic [7:0] table_ff;
    logic nxt_start;
    logic nxt_incr;
    logic nxt_err;
    logic [2*WORD_W-1:0] nxt_target;
    logic [WORD_W-1:0] nxt_speed;
    logic [7:0] nxt_table;

    always_comb begin
        nxt_start = accept;
        nxt_incr = incr_ff;
        nxt_err = err_ff;
        nxt_target = target_ff;
        nxt_speed = speed_ff;
        nxt_table = table_ff;
        if (accept) begin
            nxt_incr = incr_sel_now;
            nxt_target = pos_word;
            nxt_speed = speed_word;
            nxt_table = `ACCDEC_TABLE_NO;
            nxt_err = 1'b0;
        end
        // error holds until the next accepted start
        if (reject) begin
            nxt_err = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            start_ff <= 1'b0;
            incr_ff <= 1'b0;
            err_ff <= 1'b0;
            target_ff <= '0;
            speed_ff <= '0;
            table_ff <= `ACCDEC_RESET;
        end else begin
            start_ff <= nxt_start;
            incr_ff <= nxt_incr;
            err_ff <= nxt_err;
            target_ff <= nxt_target;
            speed_ff <= nxt_speed;
            table_ff <= nxt_table;
        end
    end

    assign REMOTE_MODE_O = remote_mode;
    assign MOVE_START_O = start_ff;
    assign MOVE_BUSY_O = (state_ff == remote_pos_pkg::ST_RUN);
    assign MOVE_INCR_O = incr_ff;
    assign MOVE_TARGET_O = target_ff;
    assign MOVE_SPEED_O = speed_ff;
    assign ACCDEC_TABLE_O = table_ff;
    assign RANGE_ERR_O = err_ff;

    // checks

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    sequence good_start_s;
        accept ##1 (start_ff && MOVE_BUSY_O);
    endsequence

    sequence bad_start_s;
        reject ##1 (err_ff && !start_ff && !MOVE_BUSY_O);
    endsequence

    start_taken_a: assert property (accept |-> good_start_s)
        else $error("accepted start did not launch a move");

    start_refused_a: assert property (reject |-> bad_start_s)
        else $error("refused start did not flag or moved anyway");

    no_remote_a: assert property (start_ff |-> $past(remote_mode) && $past(TWO_STATIONS_I))
        else $error("move started outside remote mode");

    source_digit_a: assert property (start_ff |->
        $past(POSSPEED_SOURCE_PARAM_I) == `PS_DIGIT_REMOTE)
        else $error("move started without remote source digit");

    target_concat_a: assert property (start_ff |-> target_ff == $past(pos_word))
        else $error("target not the concatenated words");

    speed_take_a: assert property (start_ff |-> speed_ff == $past(speed_word))
        else $error("speed not taken from speed word");

    accdec_table_a: assert property (start_ff |-> table_ff == `ACCDEC_TABLE_NO)
        else $error("accel/decel table not number one");

    incr_sample_a: assert property (start_ff |-> incr_ff == $past(incr_sel_now))
        else $error("abs/inc not sampled at start");

    incr_hold_a: assert property (MOVE_BUSY_O && !start_ff |-> $stable(incr_ff))
        else $error("interpretation changed during move");

    incr_sys_a: assert property (start_ff && $past(incr_sys) |-> incr_ff)
        else $error("incremental system started absolute move");

    abs_range_a: assert property (start_ff && !incr_ff |->
        $signed(target_ff) >= $signed(`POS_ABS_MIN)
        && $signed(target_ff) <= $signed(`POS_ABS_MAX))
        else $error("absolute target out of range");

    inc_range_a: assert property (start_ff && incr_ff && !$past(incr_sys) |->
        $signed(target_ff) >= $signed(`POS_INC_MIN)
        && $signed(target_ff) <= $signed(`POS_INC_MAX))
        else $error("incremental target out of range");

    incsys_range_a: assert property (start_ff && $past(incr_sys) |->
        $signed(target_ff) >= $signed(`POS_ZERO)
        && $signed(target_ff) <= $signed(`POS_INC_MAX))
        else $error("incremental system target out of range");

    cmd_digit_a: assert property (start_ff |->
        $past(COMMAND_SYSTEM_PARAM_I) inside {`CS_DIGIT_ABS, `CS_DIGIT_INCR})
        else $error("move started with bad command system digit");

    start_pulse_a: assert property (start_ff |=> !start_ff)
        else $error("start pulse longer than one cycle");

    // done in the start cycle frees the block at once, so the gap may be one cycle
    start_in_move_a: assert property (start_ff && !MOVE_DONE_I |=> !start_ff [*2])
        else $error("second start accepted during a move");

    busy_hold_a: assert property (MOVE_BUSY_O && !MOVE_DONE_I |=> MOVE_BUSY_O && !start_ff)
        else $error("move ended or restarted without done");

    busy_end_a: assert property (MOVE_BUSY_O && MOVE_DONE_I |=> !MOVE_BUSY_O)
        else $error("move did not end on done");

    err_clear_a: assert property (start_ff |-> !err_ff)
        else $error("range error left standing on accepted start");

    remote_off_a: assert property (fwd_rise && !remote_mode |=> !start_ff && $stable(err_ff))
        else $error("start acted on outside remote mode");

    word_write_a: assert property (regs_wr && (RWW_IDX_I == `RW_POS_LO_IDX) |=>
        pos_word[WORD_W-1:0] == $past(RWW_DATA_I))
        else $error("low position word not written");

    no_word_write_a: assert property (RWW_WR_I && !TWO_STATIONS_I |=>
        $stable(pos_word) && $stable(speed_word))
        else $error("remote word written with one station");

endmodule : remote_pos_cmd

/* File: bench/fieldbus_master_model.sv */
`timescale 1ns/1ps
module fieldbus_master_model (
    input wire logic clk_i,
    output logic auto_o,
    output logic src_sel_o,
    output logic abs_inc_o,
    output logic fwd_start_o,
    output logic wr_o,
    output logic [3:0] idx_o,
    output logic [15:0] data_o
);
    initial begin
        auto_o = 1'b1;
        src_sel_o = 1'b1;
        abs_inc_o = 1'b0;
        fwd_start_o = 1'b0;
        wr_o = 1'b0;
        idx_o = 4'h0;
        data_o = 16'h0000;
    end

    task automatic set_bits(input logic auto, input logic src, input logic abs_inc,
                            input logic fwd);
        auto_o = auto;
        src_sel_o = src;
        abs_inc_o = abs_inc;
        fwd_start_o = fwd;
    endtask : set_bits

    // data inverted once released so a stale word never looks valid
    task automatic put_word(input logic [3:0] idx, input logic [15:0] val);
        @(negedge clk_i);
        wr_o = 1'b1;
        idx_o = idx;
        data_o = val;
        @(negedge clk_i);
        wr_o = 1'b0;
        data_o = ~val;
    endtask : put_word

    task automatic load_move(input logic [31:0] pos, input logic [15:0] spd,
                             input logic abs_inc);
        put_word(4'h4, pos[15:0]);
        put_word(4'h5, pos[31:16]);
        put_word(4'h6, spd);
        abs_inc_o = abs_inc;
        repeat (2) @(negedge clk_i);
        fwd_start_o = 1'b1;
    endtask : load_move
endmodule : fieldbus_master_model

/* File: bench/tb_remote_pos_cmd.sv */
`timescale 1ns/1ps
module tb_remote_pos_cmd;
    typedef struct packed {
        logic [3:0] cs;
        logic abs_inc;
        logic [31:0] pos;
        logic ok;
        logic incr;
    } row_type;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic two_st = 1'b1;
    logic [3:0] cs_par = 4'h0;
    logic [3:0] ps_par = 4'h2;
    logic done = 1'b0;
    logic auto, src, absinc, fwd, wr, rmode, start, busy, incr, rerr;
    logic [3:0] idx;
    logic [15:0] wdata, spd;
    logic [31:0] tgt;
    logic [7:0] tbl;
    int err_count = 0;
    int num_checks = 0;
    row_type rows [13] = '{
        '{4'h0, 1'b0, 32'h0098967f, 1'b1, 1'b0}, '{4'h0, 1'b0, 32'h00989680, 1'b0, 1'b0},
        '{4'h0, 1'b0, 32'hff676981, 1'b1, 1'b0}, '{4'h0, 1'b0, 32'hff676980, 1'b0, 1'b0},
        '{4'h0, 1'b1, 32'h000f423f, 1'b1, 1'b1}, '{4'h0, 1'b1, 32'h000f4240, 1'b0, 1'b0},
        '{4'h0, 1'b1, 32'hfff0bdc1, 1'b1, 1'b1}, '{4'h0, 1'b1, 32'hfff0bdc0, 1'b0, 1'b0},
        '{4'h1, 1'b0, 32'h000f423f, 1'b1, 1'b1}, '{4'h1, 1'b1, 32'h00000000, 1'b1, 1'b1},
        '{4'h1, 1'b0, 32'hffffffff, 1'b0, 1'b0}, '{4'h1, 1'b1, 32'h000f4240, 1'b0, 1'b0},
        '{4'h2, 1'b0, 32'h00000000, 1'b0, 1'b0}};

    always #50 mclk = ~mclk;

    fieldbus_master_model m (.clk_i(mclk), .auto_o(auto), .src_sel_o(src),
        .abs_inc_o(absinc), .fwd_start_o(fwd), .wr_o(wr), .idx_o(idx), .data_o(wdata));

    remote_pos_cmd dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .TWO_STATIONS_I(two_st),
        .AUTO_MANUAL_SELECT_I(auto), .REMOTE_POSSPEED_SOURCE_SELECT_I(src),
        .ABS_INC_SELECT_I(absinc), .FORWARD_START_I(fwd), .COMMAND_SYSTEM_PARAM_I(cs_par),
        .POSSPEED_SOURCE_PARAM_I(ps_par), .RWW_WR_I(wr), .RWW_IDX_I(idx),
        .RWW_DATA_I(wdata), .MOVE_DONE_I(done), .REMOTE_MODE_O(rmode),
        .MOVE_START_O(start), .MOVE_BUSY_O(busy), .MOVE_INCR_O(incr),
        .MOVE_TARGET_O(tgt), .MOVE_SPEED_O(spd), .ACCDEC_TABLE_O(tbl), .RANGE_ERR_O(rerr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #100000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (10) @(negedge mclk);
        check(32'({start, busy, incr, rerr, tbl}), 32'h0);
        check(tgt, 32'h0);
        arst_n = 1'b1;
        for (int i = 0; i < 13; i++) begin
            cs_par = rows[i].cs;
            m.load_move(rows[i].pos, 16'h0100 + 16'(i), rows[i].abs_inc);
            // start pulse stands one cycle only
            @(negedge mclk);
            check(32'(start), 32'(rows[i].ok));
            check(32'(rerr), 32'(!rows[i].ok));
            check(32'(busy), 32'(rows[i].ok));
            if (rows[i].ok) begin
                check(tgt, rows[i].pos);
                check(32'(spd), 32'(16'h0100 + 16'(i)));
                check(32'(incr), 32'(rows[i].incr));
                check(32'(tbl), 32'h1);
                // late flip and a second start while busy must both be ignored
                m.set_bits(auto, src, ~absinc, 1'b0);
                @(negedge mclk);
                m.set_bits(auto, src, absinc, 1'b1);
                @(negedge mclk);
                check(32'({start, busy, incr}), 32'({2'b01, rows[i].incr}));
                done = 1'b1;
                @(negedge mclk);
                done = 1'b0;
                check(32'(busy), 32'h0);
            end
            m.set_bits(auto, src, absinc, 1'b0);
            @(negedge mclk);
        end
        ps_par = 4'h3;
        cs_par = 4'h0;
        m.load_move(32'h00001234, 16'h0077, 1'b0);
        @(negedge mclk);
        check(32'({rmode, start, busy, rerr}), 32'h1);
        ps_par = 4'h2;
        m.set_bits(1'b0, 1'b1, 1'b0, 1'b1);
        #1 check(32'(rmode), 32'h0);
        m.set_bits(1'b1, 1'b0, 1'b0, 1'b1);
        #1 check(32'(rmode), 32'h0);
        m.set_bits(1'b1, 1'b1, 1'b0, 1'b1);
        two_st = 1'b0;
        #1 check(32'(rmode), 32'h0);
        m.set_bits(1'b1, 1'b1, 1'b0, 1'b0);
        m.put_word(4'h4, 16'hbeef);
        // a start edge with one station must be ignored as well
        m.set_bits(1'b1, 1'b1, 1'b0, 1'b1);
        @(negedge mclk);
        check(32'({start, busy, rerr}), 32'h1);
        m.set_bits(1'b1, 1'b1, 1'b0, 1'b0);
        @(negedge mclk);
        two_st = 1'b1;
        m.set_bits(1'b1, 1'b1, 1'b0, 1'b1);
        @(negedge mclk);
        check(32'({start, rerr}), 32'h2);
        check(tgt, 32'h00001234);
        check(32'(spd), 32'h77);
        // reset in mid-move; start still high, so release counts as a fresh edge
        arst_n = 1'b0;
        #1 check(32'({start, busy, rerr, tbl}), 32'h0);
        check(tgt, 32'h0);
        @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        check(32'({start, busy, tbl}), 32'h301);
        check(tgt, 32'h0);
        check(32'(spd), 32'h0);
        final_report();
    end
endmodule : tb_remote_pos_cmd
